// [cabbo_alu.sv]
// cabbo_alu.sv: combinational datapath for add, add with carry, shift and bit clear
`timescale 1ns/1ps
`include "cabbo_consts.svh"
module cabbo_alu
  import cabbo_pkg::*;
(
  // operands in, results out
  cabbo_alu_if.alu bus
);
  logic [`CABBO_DATA_W:0] sum;
  logic [`CABBO_NIB_MSB+1:0] nib;
  logic cin_eff;

  // only add with carry folds the stored carry in
  assign cin_eff = (bus.op == CABBO_OP_ADDC) ? bus.cin : 1'h0;
  assign sum = {1'h0, bus.a} + {1'h0, bus.f} + {8'h00, cin_eff};
  assign nib = {1'h0, bus.a[`CABBO_NIB_MSB:0]} + {1'h0, bus.f[`CABBO_NIB_MSB:0]}
             + {4'h0, cin_eff};
  assign bus.bit_val = bus.f[bus.bit_sel];

  always_comb begin
    bus.res = bus.f;
    bus.c = 1'h0;
    bus.hc = 1'h0;
    bus.wr_c = 1'h0;
    bus.wr_hc = 1'h0;
    bus.wr_z = 1'h0;
    unique case (bus.op)
      CABBO_OP_ADD, CABBO_OP_ADDC: begin
        bus.res = sum[`CABBO_DATA_W-1:0];
        bus.c = sum[`CABBO_DATA_W];
        bus.hc = nib[`CABBO_NIB_MSB+1];
        bus.wr_c = 1'h1;
        bus.wr_hc = 1'h1;
        bus.wr_z = 1'h1;
      end
      CABBO_OP_ASR: begin
        bus.res = {bus.f[`CABBO_DATA_W-1], bus.f[`CABBO_DATA_W-1:1]};
        bus.c = bus.f[0];
        bus.wr_c = 1'h1;
        bus.wr_z = 1'h1;
      end
      CABBO_OP_BCLR: begin
        bus.res = bus.f & ~(8'h01 << bus.bit_sel);
      end
      default: begin
        bus.res = bus.f;
      end
    endcase
  end

  assign bus.z = (bus.res == 8'h00);
endmodule : cabbo_alu

// [cabbo_alu_if.sv]
// cabbo_alu_if.sv: operand and result bundle between the core sequencer and its datapath
`timescale 1ns/1ps
`include "cabbo_consts.svh"
interface cabbo_alu_if;
  import cabbo_pkg::*;
  cabbo_op_t op;
  logic [`CABBO_DATA_W-1:0] a;
  logic [`CABBO_DATA_W-1:0] f;
  logic cin;
  logic [`CABBO_BIT_W-1:0] bit_sel;
  logic [`CABBO_DATA_W-1:0] res;
  logic c;
  logic hc;
  logic z;
  logic wr_c;
  logic wr_hc;
  logic wr_z;
  logic bit_val;
  modport core (output op, a, f, cin, bit_sel,
                input res, c, hc, z, wr_c, wr_hc, wr_z, bit_val);
  modport alu (input op, a, f, cin, bit_sel,
               output res, c, hc, z, wr_c, wr_hc, wr_z, bit_val);
endinterface : cabbo_alu_if

// [cabbo_consts.svh]
// cabbo_consts.svh: widths, ranges and field positions of the arithmetic, bit and branch core
`ifndef CABBO_CONSTS_SVH
`define CABBO_CONSTS_SVH
`define CABBO_DATA_W 8
`define CABBO_ADDR_W 7
`define CABBO_ADDR_MAX 7'h7F
`define CABBO_BIT_W 3
`define CABBO_PC_W 15
`define CABBO_OFS_W 9
`define CABBO_OFS_MIN (-256)
`define CABBO_OFS_MAX 255
`define CABBO_NIB_MSB 3
`define CABBO_DEST_ACC 1'h0
`define CABBO_DEST_REG 1'h1
`define CABBO_PC_STEP 15'h0001
`define CABBO_PC_SKIP 15'h0002
`define CABBO_ACC_RST 8'h00
`define CABBO_PC_RST 15'h0000
`endif

// [cabbo_core.sv]
// cabbo_core.sv: executor for add, shift, bit and branch operations, one cycle each, two for a taken skip or a jump
`timescale 1ns/1ps
`include "cabbo_consts.svh"
module cabbo_core
  import cabbo_pkg::*;
#(
  parameter int ADDR_W = `CABBO_ADDR_W,
  parameter int PC_W = `CABBO_PC_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction slot
  input wire logic op_valid,
  input wire cabbo_op_t op,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic target_sel,
  input wire logic [`CABBO_BIT_W-1:0] bit_sel,
  input wire logic [`CABBO_OFS_W-1:0] offset,
  output logic op_ready,
  // data memory
  input wire logic [`CABBO_DATA_W-1:0] mem_rdata,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_waddr,
  output logic [`CABBO_DATA_W-1:0] mem_wdata,
  // core state
  output logic [`CABBO_DATA_W-1:0] acc,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  output logic [PC_W-1:0] pc,
  output logic idle_cycle
);
  if (ADDR_W != `CABBO_ADDR_W || PC_W <= `CABBO_OFS_W) begin : g_bad_width
    $error("cabbo_core: unsupported address or pc width");
  end

  cabbo_state_t state_q;
  logic [`CABBO_DATA_W-1:0] acc_q;
  logic c_q;
  logic hc_q;
  logic z_q;
  logic [PC_W-1:0] pc_q;
  logic we_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [`CABBO_DATA_W-1:0] wdata_q;
  logic exec;
  logic data_op;
  logic arith_op;
  logic skip_now;
  logic [`CABBO_DATA_W-1:0] f_fwd;
  logic [PC_W-1:0] ofs_ext;

  cabbo_alu_if alu_bus ();

  cabbo_alu u_alu (
    .bus(alu_bus.alu)
  );

  assign exec = op_valid && (state_q == CABBO_ST_EXEC);
  assign arith_op = (op == CABBO_OP_ADD) || (op == CABBO_OP_ADDC) || (op == CABBO_OP_ASR);
  assign data_op = arith_op || (op == CABBO_OP_BCLR);
  // a write still in flight is bypassed so a read-after-write sees the new byte
  assign f_fwd = (we_q && waddr_q == reg_addr) ? wdata_q : mem_rdata;
  assign skip_now = exec && (op == CABBO_OP_SKPL) && !alu_bus.bit_val;
  assign ofs_ext = {{(PC_W-`CABBO_OFS_W){offset[`CABBO_OFS_W-1]}}, offset};

  assign alu_bus.op = op;
  assign alu_bus.a = acc_q;
  assign alu_bus.f = f_fwd;
  assign alu_bus.cin = c_q;
  assign alu_bus.bit_sel = bit_sel;

  // sequencer: a taken skip or jump turns the following slot into an idle cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CABBO_ST_EXEC;
    end else begin
      unique case (state_q)
        CABBO_ST_EXEC: begin
          if (skip_now || (exec && op == CABBO_OP_RJMP)) begin
            state_q <= CABBO_ST_IDLE;
          end
        end
        CABBO_ST_IDLE: begin
          state_q <= CABBO_ST_EXEC;
        end
        default: begin
          state_q <= CABBO_ST_EXEC;
        end
      endcase
    end
  end

  // program counter holds the address of the instruction in the slot; in an idle cycle it already holds the next one to execute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= `CABBO_PC_RST;
    end else if (exec) begin
      if (op == CABBO_OP_RJMP) begin
        pc_q <= PC_W'(pc_q + `CABBO_PC_STEP + ofs_ext);
      end else if (skip_now) begin
        pc_q <= PC_W'(pc_q + `CABBO_PC_SKIP);
      end else begin
        pc_q <= PC_W'(pc_q + `CABBO_PC_STEP);
      end
    end
  end

  // accumulator destination
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= `CABBO_ACC_RST;
    end else if (exec && arith_op && target_sel == `CABBO_DEST_ACC) begin
      acc_q <= alu_bus.res;
    end
  end

  // register write-back; bit clear always writes the register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_q <= 1'h0;
      waddr_q <= '0;
      wdata_q <= 8'h00;
    end else begin
      we_q <= exec && ((arith_op && target_sel == `CABBO_DEST_REG)
              || op == CABBO_OP_BCLR);
      if (exec && data_op) begin
        waddr_q <= reg_addr;
        wdata_q <= alu_bus.res;
      end
    end
  end

  // status flags; skip, jump and bit clear leave them untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= 1'h0;
      hc_q <= 1'h0;
      z_q <= 1'h0;
    end else if (exec) begin
      if (alu_bus.wr_c) begin
        c_q <= alu_bus.c;
      end
      if (alu_bus.wr_hc) begin
        hc_q <= alu_bus.hc;
      end
      if (alu_bus.wr_z) begin
        z_q <= alu_bus.z;
      end
    end
  end

  assign op_ready = (state_q == CABBO_ST_EXEC);
  assign idle_cycle = (state_q == CABBO_ST_IDLE);
  assign mem_we = we_q;
  assign mem_waddr = waddr_q;
  assign mem_wdata = wdata_q;
  assign acc = acc_q;
  assign carry_flag = c_q;
  assign half_carry_flag = hc_q;
  assign zero_flag = z_q;
  assign pc = pc_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  add_acc_sum_a: assert property (
    exec && op == CABBO_OP_ADD && target_sel == `CABBO_DEST_ACC
    |=> acc_q == 8'($past(acc_q) + $past(f_fwd)) && !we_q)
    else $error("add to accumulator gave a wrong sum");
  dest_reg_a: assert property (
    exec && arith_op && target_sel == `CABBO_DEST_REG
    |=> we_q && waddr_q == $past(reg_addr) && $stable(acc_q))
    else $error("register destination not written back");
  asr_shape_a: assert property (
    exec && op == CABBO_OP_ASR
    |=> wdata_q == {$past(f_fwd[7]), $past(f_fwd[7:1])} && c_q == $past(f_fwd[0]))
    else $error("shift right result or carry wrong");
  asr_keeps_hc_a: assert property (
    exec && op == CABBO_OP_ASR |=> $stable(hc_q) && z_q == (wdata_q == 8'h00))
    else $error("shift right disturbed half carry or zero wrong");
  addc_sum_a: assert property (
    exec && op == CABBO_OP_ADDC
    |=> wdata_q == 8'($past(acc_q) + $past(f_fwd) + {7'h00, $past(c_q)}))
    else $error("add with carry gave a wrong sum");
  bclr_bit_a: assert property (
    exec && op == CABBO_OP_BCLR
    |=> we_q && !wdata_q[$past(bit_sel)] && $stable(c_q) && $stable(hc_q) && $stable(z_q)
        && (wdata_q | (8'h01 << $past(bit_sel))) == ($past(f_fwd) | (8'h01 << $past(bit_sel))))
    else $error("bit clear changed the wrong bits or flags");
  skip_idle_a: assert property (
    exec && op == CABBO_OP_SKPL
    |=> idle_cycle == !$past(alu_bus.bit_val) ##1 (!idle_cycle || !$past(idle_cycle)))
    else $error("skip produced the wrong idle cycle");
  jump_target_a: assert property (
    exec && op == CABBO_OP_RJMP |=> pc_q == PC_W'($past(pc_q) + 1 + $past(ofs_ext)))
    else $error("relative jump target wrong");
  jump_two_a: assert property (
    exec && op == CABBO_OP_RJMP
    |=> idle_cycle && $stable(c_q) && $stable(hc_q) && $stable(z_q) ##1 !idle_cycle)
    else $error("relative jump not two cycles or touched a flag");
  idle_hold_a: assert property (
    idle_cycle |=> $stable(pc_q) && $stable(acc_q) && !we_q && !idle_cycle)
    else $error("idle cycle did work");
  add_flags_a: assert property (
    exec && op == CABBO_OP_ADD
    |=> c_q == ({1'h0, $past(acc_q)} + {1'h0, $past(f_fwd)} > 9'h0FF)
        && hc_q == ({1'h0, $past(acc_q[3:0])} + {1'h0, $past(f_fwd[3:0])} > 5'h0F)
        && z_q == (($past(target_sel) ? wdata_q : acc_q) == 8'h00))
    else $error("add flags wrong");
  fwd_next_a: assert property (
    exec && (data_op && target_sel == `CABBO_DEST_REG || op == CABBO_OP_BCLR)
    ##1 reg_addr == waddr_q |-> we_q && alu_bus.f == wdata_q)
    else $error("written byte not visible to next instruction");

  add_reg_c: cover property (exec && op == CABBO_OP_ADDC && target_sel == `CABBO_DEST_REG);
  skip_taken_c: cover property (skip_now ##1 idle_cycle);
  jump_back_c: cover property (exec && op == CABBO_OP_RJMP && offset[`CABBO_OFS_W-1]);
  bclr_fwd_c: cover property (exec && op == CABBO_OP_BCLR ##1 exec && we_q
                              && reg_addr == waddr_q);
endmodule : cabbo_core

// [cabbo_mem_model.sv]
// cabbo_mem_model.sv: data register file seen from the far side of the core
`timescale 1ns/1ps
`include "cabbo_consts.svh"
module cabbo_mem_model (
  // clock
  input wire logic clk,
  // read port, combinational
  input wire logic [`CABBO_ADDR_W-1:0] addr,
  output logic [`CABBO_DATA_W-1:0] rdata,
  // write port, taken on the edge
  input wire logic we,
  input wire logic [`CABBO_ADDR_W-1:0] waddr,
  input wire logic [`CABBO_DATA_W-1:0] wdata
);
  logic [`CABBO_DATA_W-1:0] mem [0:127];
  // every address is always selected, so no released-bus value is needed
  assign rdata = mem[addr];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule : cabbo_mem_model

// [cabbo_pkg.sv]
// cabbo_pkg.sv: operation and sequencing types of the arithmetic, bit and branch core
package cabbo_pkg;
  typedef enum logic [5:0] {
    CABBO_OP_ADD  = 6'h01,
    CABBO_OP_ADDC = 6'h02,
    CABBO_OP_ASR  = 6'h04,
    CABBO_OP_BCLR = 6'h08,
    CABBO_OP_SKPL = 6'h10,
    CABBO_OP_RJMP = 6'h20
  } cabbo_op_t;
  typedef enum logic [1:0] {
    CABBO_ST_EXEC = 2'h1,
    CABBO_ST_IDLE = 2'h2
  } cabbo_state_t;
endpackage : cabbo_pkg

// [tb.sv]
// tb.sv: self-checking bench of the arithmetic, bit and branch core
`timescale 1ns/1ps
`include "cabbo_consts.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  import cabbo_pkg::*;
  typedef struct packed {logic [26:0] st; logic we; logic [14:0] wr;} cabbo_note_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic op_valid = 1'h0;
  cabbo_op_t op = CABBO_OP_ADD;
  logic [6:0] reg_addr = 7'h00;
  logic target_sel = 1'h0;
  logic [2:0] bit_sel = 3'h0;
  logic [8:0] offset = 9'h000;
  logic op_ready, mem_we, carry_flag, half_carry_flag, zero_flag, idle_cycle, took;
  logic [7:0] mem_rdata, mem_wdata, acc, m_acc;
  logic [6:0] mem_waddr;
  logic [14:0] pc, m_pc;
  logic m_c, m_hc, m_z;
  logic [7:0] sh [0:127];
  logic [31:0] rv;
  logic [26:0] st_seen;
  assign st_seen = {acc, carry_flag, half_carry_flag, zero_flag, pc, idle_cycle};
  int n_errors = 0;
  int checks = 0;
  cabbo_note_t q[$];
  cabbo_note_t nt;
  cabbo_op_t ops [6] = '{CABBO_OP_ADD, CABBO_OP_ADDC, CABBO_OP_ASR, CABBO_OP_BCLR,
                         CABBO_OP_SKPL, CABBO_OP_RJMP};

  always #10 clk = ~clk;

  cabbo_core #(.ADDR_W(7), .PC_W(15)) i_cabbo_core (.clk(clk), .rst_n(rst_n),
    .op_valid(op_valid), .op(op), .reg_addr(reg_addr), .target_sel(target_sel),
    .bit_sel(bit_sel), .offset(offset), .op_ready(op_ready), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .acc(acc),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .pc(pc), .idle_cycle(idle_cycle));
  cabbo_mem_model i_cabbo_mem_model (.clk(clk), .addr(reg_addr), .rdata(mem_rdata),
    .we(mem_we), .waddr(mem_waddr), .wdata(mem_wdata));

  task print_verdict;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // one instruction: reference model, drive, note; an idle slot is filled with junk
  task exec(input cabbo_op_t o, input logic [6:0] a, input logic t, input logic [2:0] b,
            input logic [8:0] k);
    logic [7:0] f, r;
    logic [8:0] s;
    logic [4:0] h;
    logic w, skip, cin;
    @(negedge clk);
    f = sh[a];
    r = f;
    w = 1'h0;
    skip = 1'h0;
    cin = (o == CABBO_OP_ADDC) ? m_c : 1'h0;
    case (o)
      CABBO_OP_ADD, CABBO_OP_ADDC: begin
        s = {1'h0, m_acc} + {1'h0, f} + {8'h00, cin};
        h = {1'h0, m_acc[3:0]} + {1'h0, f[3:0]} + {4'h0, cin};
        r = s[7:0];
        m_c = s[8];
        m_hc = h[4];
      end
      CABBO_OP_ASR: begin
        r = {f[7], f[7:1]};
        m_c = f[0];
      end
      CABBO_OP_BCLR: r[b] = 1'h0;
      CABBO_OP_SKPL: skip = ~f[b];
      default: skip = 1'h1;
    endcase
    if (o == CABBO_OP_ADD || o == CABBO_OP_ADDC || o == CABBO_OP_ASR) begin
      m_z = (r == 8'h00);
      if (t) w = 1'h1;
      else m_acc = r;
    end
    if (o == CABBO_OP_BCLR) w = 1'h1;
    if (w) sh[a] = r;
    if (o == CABBO_OP_RJMP) m_pc = m_pc + 15'h0001 + {{6{k[8]}}, k};
    else m_pc = m_pc + (skip ? 15'h0002 : 15'h0001);
    op_valid = 1'h1;
    op = o;
    reg_addr = a;
    target_sel = t;
    bit_sel = b;
    offset = k;
    q.push_back({{m_acc, m_c, m_hc, m_z, m_pc, skip}, w, {a, r}});
    if (skip) begin
      @(negedge clk);
      rv = $urandom;
      op = ops[rv[31:24] % 6];
      reg_addr = rv[6:0];
      `CHK("op_ready in idle", 1'h0, op_ready);
      `CHK("idle_cycle", 1'h1, idle_cycle);
    end
  endtask : exec

  // results show one cycle after the slot is taken
  always @(posedge clk) took <= rst_n && op_valid && op_ready;
  always @(negedge clk) begin
    if (took) begin
      nt = q.pop_front();
      `CHK("core state", nt.st, st_seen);
      `CHK("mem_we", nt.we, mem_we);
      if (nt.we) `CHK("write addr data", nt.wr, {mem_waddr, mem_wdata});
    end
  end

  initial begin
    #100000;
    n_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    void'($urandom(59));
    for (int i = 0; i < 128; i++) sh[i] = 8'($urandom);
    sh[0] = 8'h80;
    sh[127] = 8'h80;
    for (int i = 0; i < 128; i++) i_cabbo_mem_model.mem[i] = sh[i];
    m_acc = 8'h00;
    {m_c, m_hc, m_z} = 3'h0;
    m_pc = 15'h0000;
    repeat (10) @(negedge clk);
    `CHK("reset state", {8'h00, 3'h0, 15'h0000, 3'h1}, {st_seen, mem_we, op_ready});
    rst_n = 1'h1;
    // boundaries first: top address, carry out with zero result, back-to-back reuse
    exec(CABBO_OP_ADD, 7'h7F, 1'h0, 3'h0, 9'h000);
    exec(CABBO_OP_ADD, 7'h00, 1'h1, 3'h0, 9'h000);
    exec(CABBO_OP_ADDC, 7'h00, 1'h0, 3'h0, 9'h000);
    exec(CABBO_OP_ASR, 7'h7F, 1'h1, 3'h0, 9'h000);
    exec(CABBO_OP_BCLR, 7'h7F, 1'h0, 3'h7, 9'h000);
    exec(CABBO_OP_SKPL, 7'h7F, 1'h0, 3'h7, 9'h000);
    exec(CABBO_OP_SKPL, 7'h7F, 1'h0, 3'h6, 9'h000);
    exec(CABBO_OP_RJMP, 7'h00, 1'h0, 3'h0, 9'h100);
    exec(CABBO_OP_RJMP, 7'h00, 1'h0, 3'h0, 9'h0FF);
    for (int n = 0; n < 300; n++) begin
      rv = $urandom;
      if (rv[23:21] == 3'h0) begin
        @(negedge clk);
        op_valid = 1'h0;
      end
      exec(ops[rv[31:24] % 6], rv[6:0], rv[7], rv[10:8], rv[19:11]);
    end
    @(negedge clk);
    op_valid = 1'h0;
    repeat (2) @(negedge clk);
    `CHK("notes left", 0, q.size());
    print_verdict();
  end
endmodule : tb
